// >>> port_param_word_loader.v
// Loader spreading memory image words into per-port config fields
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "port_param_consts.vh"

module port_param_word_loader (
   input  wire         mclk,        // Core clock, 250 MHz
   input  wire         sys_rst,     // Synchronous reset, high
   input  wire         ee_valid,    // Image word present, one cycle
   input  wire [7:0]   ee_addr,     // Byte address of that word
   input  wire [15:0]  ee_word,     // Image word
   input  wire         ee_last,     // Image fully read, one cycle
   input  wire [10:0]  reg_addr,    // Register bus address
   input  wire [31:0]  reg_wdata,   // Register bus write data
   input  wire         reg_wr,      // Register write strobe
   input  wire         reg_rd,      // Register read strobe
   output wire [31:0]  reg_rdata,   // Read data, cycle after strobe
   output wire         ports_ready, // Ports may leave initialisation
   output wire [767:0] cfg_flat     // All port registers to port logic
);

   // Loader states
   localparam [1:0] ST_IDLE = 2'h0;   // Waiting for the image
   localparam [1:0] ST_LOAD = 2'h1;   // Words arriving
   localparam [1:0] ST_DONE = 2'h2;   // Image complete

   wire [15:0] ones = 16'hffff;       // Source for field masks

   reg  [1:0]  state_q;               // Loader state
   reg  [1:0]  state_d;
   reg         ready_q;               // Registered ready level
   reg  [31:0] ctl_q;                 // Loader control register
   reg  [7:0]  applied_q;             // Words placed into fields
   reg  [7:0]  unmapped_q;            // Words with no destination
   reg  [31:0] rdata_q;               // Read data register

   // Word decode
   wire [3:0]  grp  = ee_addr[`EE_GRP];
   wire [1:0]  port = ee_addr[`EE_PORT];
   wire        accepting;             // Loader takes words now
   wire        addr_ok;               // Even address, bit 3 clear, port 0..2
   reg         map_hit;               // Group has a target here
   wire        take;                  // Word really applied

   // Per-register lane masks and values for the addressed port
   reg  [31:0] m_tim, m_mod, m_p3, m_p5, m_prx, m_slt, m_vr, m_vm;
   reg  [31:0] d_tim, d_mod, d_p3, d_p5, d_prx, d_slt, d_vr, d_vm;
   wire [255:0] lane_mask;
   wire [255:0] lane_data;

   // Register bus decode
   wire [1:0]  page = reg_addr[`BUS_PAGE];
   wire [8:0]  off  = reg_addr[`BUS_OFF];
   reg  [2:0]  bus_idx;               // Register index of offset
   reg         bus_hit;               // Offset maps to a register
   wire        page_port;             // Page is port 0..2
   wire [31:0] status;                // Loader status word
   wire [31:0] port_word;             // Addressed port register

   // Words are ignored once the ports are released, so late
   // image words cannot overwrite values software has set
   assign accepting = ctl_q[`CTL_LOAD_EN] && (state_q != ST_DONE);
   assign addr_ok   = !ee_addr[`EE_HI_BIT] && !ee_addr[`EE_ODD_BIT] &&
                      (port != 2'h3);
   assign take      = ee_valid && accepting && addr_ok && map_hit;

   // Field placement for one word
   always @* begin
      map_hit = 1'b1;
      m_tim = `CFG_REG_RST;
      m_mod = `CFG_REG_RST;
      m_p3  = `CFG_REG_RST;
      m_p5  = `CFG_REG_RST;
      m_prx = `CFG_REG_RST;
      m_slt = `CFG_REG_RST;
      m_vr  = `CFG_REG_RST;
      m_vm  = `CFG_REG_RST;
      d_tim = `CFG_REG_RST;
      d_mod = `CFG_REG_RST;
      d_p3  = `CFG_REG_RST;
      d_p5  = `CFG_REG_RST;
      d_prx = `CFG_REG_RST;
      d_slt = `CFG_REG_RST;
      d_vr  = `CFG_REG_RST;
      d_vm  = `CFG_REG_RST;
      case (grp)
         `GRP_PM: begin
            m_mod[`F_PMLINK] = ones[`S_PMLINK];
            d_mod[`F_PMLINK] = ee_word[`S_PMLINK];
            m_mod[`F_RXPOL]  = ones[`S_RXPOL];
            d_mod[`F_RXPOL]  = ee_word[`S_RXPOL];
            m_tim[`F_VGA]    = ones[`S_VGA];
            d_tim[`F_VGA]    = ee_word[`S_VGA];
            m_p5[`F_PHY5]    = ones[`S_PHY5];
            d_p5[`F_PHY5]    = ee_word[`S_PHY5];
         end
         `GRP_SLOT_LO: begin
            // Port 0 has no slot word in the image
            map_hit = (port != 2'h0);
            m_slt[`F_LOW]    = ones[`S_WORD];
            d_slt[`F_LOW]    = ee_word[`S_WORD];
         end
         `GRP_SLOT_HI: begin
            map_hit = (port != 2'h0);
            m_slt[`F_HIGH]   = ones[`S_WORD];
            d_slt[`F_HIGH]   = ee_word[`S_WORD];
         end
         `GRP_PHY3_LO: begin
            m_p3[`F_LOW]     = ones[`S_WORD];
            d_p3[`F_LOW]     = ee_word[`S_WORD];
         end
         `GRP_PHY3_HI: begin
            m_p3[`F_HIGH]    = ones[`S_WORD];
            d_p3[`F_HIGH]    = ee_word[`S_WORD];
         end
         `GRP_REPLAY: begin
            m_tim[`F_REPLAY] = ones[`S_REPLAY];
            d_tim[`F_REPLAY] = ee_word[`S_REPLAY];
            m_prx[`F_TSCNT]  = ones[`S_TSCNT];
            d_prx[`F_TSCNT]  = ee_word[`S_TSCNT];
         end
         `GRP_ACK: begin
            m_tim[`F_ACK]    = ones[`S_ACK];
            d_tim[`F_ACK]    = ee_word[`S_ACK];
         end
         `GRP_VC1: begin
            m_vr[`F_VC1SLOT] = ones[`S_VC1SLOT];
            d_vr[`F_VC1SLOT] = ee_word[`S_VC1SLOT];
            m_vm[`F_VC1MAP]  = ones[`S_VC1MAP];
            d_vm[`F_VC1MAP]  = ee_word[`S_VC1MAP];
         end
         default: begin
            // Earlier words of the image belong to other logic
            map_hit = 1'b0;
         end
      endcase
   end

   // Lanes in register index order
   assign lane_mask = {m_vm, m_vr, m_slt, m_prx, m_p5, m_p3, m_mod, m_tim};
   assign lane_data = {d_vm, d_vr, d_slt, d_prx, d_p5, d_p3, d_mod, d_tim};

   // Offset to register index
   always @* begin
      bus_hit = 1'b1;
      case (off)
         `OFF_TIMERS:  bus_idx = `IDX_TIMERS;
         `OFF_MODES:   bus_idx = `IDX_MODES;
         `OFF_PHY3:    bus_idx = `IDX_PHY3;
         `OFF_PHY5:    bus_idx = `IDX_PHY5;
         `OFF_PHYRX:   bus_idx = `IDX_PHYRX;
         `OFF_SLOTCAP: bus_idx = `IDX_SLOTCAP;
         `OFF_VC1RES:  bus_idx = `IDX_VC1RES;
         `OFF_VC1MAP:  bus_idx = `IDX_VC1MAP;
         default: begin
            bus_idx = `IDX_TIMERS;
            bus_hit = 1'b0;
         end
      endcase
   end

   assign page_port = (page != `PAGE_LOADER);

   // One register store per port
   genvar p;
   generate
      for (p = 0; p < `NUM_PORTS; p = p + 1) begin : g_port
         localparam [1:0] PNUM = p;
         wire sel_ld  = take && (port == PNUM);
         wire sel_bus = reg_wr && page_port && bus_hit && (page == PNUM);
         // a load changes only masked bits; on those bits a loader word beats a
         // bus write to the same register in the same cycle, which sets the rest
         port_cfg_store u_store (
            .mclk      (mclk),
            .sys_rst   (sys_rst),
            .ld_mask   (sel_ld ? lane_mask : 256'h0),
            .ld_data   (lane_data),
            .bus_we    (sel_bus),
            .bus_idx   (bus_idx),
            .bus_wdata (reg_wdata),
            .regs_flat (cfg_flat[p*256 +: 256])
         );
      end
   endgenerate

   // Loader sequencing
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (ctl_q[`CTL_FORCE] || ee_last) begin
               state_d = ST_DONE;
            end else if (ee_valid && accepting) begin
               state_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            // Last word is applied in the cycle ee_last is seen
            if (ctl_q[`CTL_FORCE] || ee_last) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            state_d = ST_DONE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // Restart reopens the image window for a reload
      if (reg_wr && page == `PAGE_LOADER && off == `OFF_LDCTL &&
          reg_wdata[`CTL_RESTART]) begin
         state_d = ST_IDLE;
      end
   end

   // State, ready level and counters
   always @(posedge mclk) begin
      if (sys_rst) begin
         state_q    <= ST_IDLE;
         ready_q    <= 1'b0;
         applied_q  <= 8'h00;
         unmapped_q <= 8'h00;
      end else begin
         state_q <= state_d;
         // ports released once ee_last is seen or the force bit is set
         ready_q <= (state_d == ST_DONE);
         if (take) begin
            applied_q <= applied_q + 8'h01;
         end
         if (ee_valid && accepting && !(addr_ok && map_hit)) begin
            unmapped_q <= unmapped_q + 8'h01;
         end
      end
   end

   // Loader control register; restart bit is not stored
   always @(posedge mclk) begin
      if (sys_rst) begin
         ctl_q <= `LDCTL_RST;
      end else if (reg_wr && page == `PAGE_LOADER &&
                   off == `OFF_LDCTL) begin
         ctl_q <= reg_wdata & ~(32'h1 << `CTL_RESTART);
      end
   end

   assign status = {8'h00, unmapped_q, applied_q, 6'h00,
                    (state_q == ST_LOAD), ready_q};

   assign port_word = cfg_flat[{page, bus_idx, 5'h00} +: 32];

   // Read data for one cycle after the strobe, zero otherwise
   always @(posedge mclk) begin
      if (sys_rst) begin
         rdata_q <= 32'h00000000;
      end else if (!reg_rd) begin
         rdata_q <= 32'h00000000;
      end else if (page_port) begin
         // loaded fields read back over the bus
         rdata_q <= bus_hit ? port_word : 32'h00000000;
      end else if (off == `OFF_LDCTL) begin
         rdata_q <= ctl_q;
      end else if (off == `OFF_LDSTAT) begin
         rdata_q <= status;
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   assign reg_rdata   = rdata_q;
   assign ports_ready = ready_q;

endmodule
`default_nettype wire

// >>> port_param_consts.vh
// Constants for the per-port configuration word loader
`ifndef PORT_PARAM_CONSTS_VH
`define PORT_PARAM_CONSTS_VH

// Configuration register byte offsets inside one port
`define OFF_TIMERS   9'h070
`define OFF_MODES    9'h074
`define OFF_PHY3     9'h080
`define OFF_PHY5     9'h088
`define OFF_PHYRX    9'h08c
`define OFF_SLOTCAP  9'h0d4
`define OFF_VC1RES   9'h15c
`define OFF_VC1MAP   9'h160
// Loader control and status, in the loader page
`define OFF_LDCTL    9'h1f0
`define OFF_LDSTAT   9'h1f4

// Register index inside a port's store
`define IDX_TIMERS   3'h0
`define IDX_MODES    3'h1
`define IDX_PHY3     3'h2
`define IDX_PHY5     3'h3
`define IDX_PHYRX    3'h4
`define IDX_SLOTCAP  3'h5
`define IDX_VC1RES   3'h6
`define IDX_VC1MAP   3'h7
`define NUM_REGS     8
`define NUM_PORTS    3

// Register bus address layout: page select and byte offset
`define BUS_PAGE     10:9
`define BUS_OFF      8:0
`define PAGE_LOADER  2'h3

// Memory word groups: high nibble of the word address
`define GRP_PM       4'h8
`define GRP_SLOT_LO  4'h9
`define GRP_SLOT_HI  4'ha
`define GRP_PHY3_LO  4'hb
`define GRP_PHY3_HI  4'hc
`define GRP_REPLAY   4'hd
`define GRP_ACK      4'he
`define GRP_VC1      4'hf
// Word address fields: group, port, must-be-zero bits
`define EE_GRP       7:4
`define EE_PORT      2:1
`define EE_HI_BIT    3
`define EE_ODD_BIT   0

// Source fields in a memory word and their destinations
`define S_PMLINK     5:0
`define F_PMLINK     13:8
`define S_RXPOL      6:6
`define F_RXPOL      14:14
`define S_VGA        7:7
`define F_VGA        31:31
`define S_PHY5       15:8
`define F_PHY5       31:24
`define S_WORD       15:0
`define F_LOW        15:0
`define F_HIGH       31:16
`define S_REPLAY     12:0
`define F_REPLAY     12:0
`define S_TSCNT      14:13
`define F_TSCNT      25:24
`define S_ACK        14:0
`define F_ACK        30:16
`define S_VC1SLOT    6:0
`define F_VC1SLOT    22:16
`define S_VC1MAP     15:8
`define F_VC1MAP     7:0

// Reset values
`define CFG_REG_RST  32'h00000000
`define LDCTL_RST    32'h00000001
// Loader control bits
`define CTL_LOAD_EN  0
`define CTL_FORCE    1
`define CTL_RESTART  2
// Loader status fields
`define ST_READY     0
`define ST_LOADING   1
`define ST_APPLIED   15:8
`define ST_UNMAPPED  23:16

`endif

// >>> port_cfg_store.v
// Configuration register store of one switch port
`timescale 1ns/10ps
`default_nettype none
`include "port_param_consts.vh"

module port_cfg_store (
   input  wire         mclk,      // Core clock
   input  wire         sys_rst,   // Synchronous reset, high
   input  wire [255:0] ld_mask,   // Loader bit masks, 32 per register
   input  wire [255:0] ld_data,   // Loader bit values, 32 per register
   input  wire         bus_we,    // Register bus write to this port
   input  wire [2:0]   bus_idx,   // Register index of that write
   input  wire [31:0]  bus_wdata, // Register bus write data
   output wire [255:0] regs_flat  // All register contents, flop outputs
);

   genvar i;
   generate
      for (i = 0; i < `NUM_REGS; i = i + 1) begin : g_reg
         localparam [2:0] IDX = i;
         reg  [31:0] word_q;   // Stored register
         wire [31:0] base;     // Value after any bus write
         wire [31:0] msk;      // Loader lane mask
         assign msk  = ld_mask[i*32 +: 32];
         assign base = (bus_we && bus_idx == IDX) ? bus_wdata : word_q;
         // Loader bits overlay the bus value; other bits untouched
         always @(posedge mclk) begin
            if (sys_rst) begin
               word_q <= `CFG_REG_RST;
            end else begin
               word_q <= (base & ~msk) | (ld_data[i*32 +: 32] & msk);
            end
         end
         assign regs_flat[i*32 +: 32] = word_q;
      end
   endgenerate

endmodule
`default_nettype wire

// >>> ee_image_src.sv
// Model of the serial image memory streaming words to the loader
`timescale 1ns/10ps
`default_nettype none

module ee_image_src (
   input  wire logic        mclk,     // Core clock
   input  wire logic        sys_rst,  // Synchronous reset, high
   input  wire logic        start,    // Begin one image pass
   input  wire logic        slow,     // Idle cycle after every word
   output logic             ee_valid, // Word present
   output logic [7:0]       ee_addr,  // Word byte address
   output logic [15:0]      ee_word,  // Word data
   output logic             ee_last   // Image complete
);
   logic [4:0] idx_q;  // Next word to send
   logic       busy_q; // Pass in progress
   logic       gap_q;  // Idle slot in slow mode

   // Image contents, a pattern of the address
   function automatic logic [15:0] pat(input logic [7:0] a);
      pat = {a ^ 8'h5a, a * 8'h25};
   endfunction

   // Word order: power words, one unmapped, slot halves, groups B to F
   function automatic logic [7:0] adr(input logic [4:0] i);
      logic [4:0] j;
      j = i - 5'd8;
      if (i < 5'd3) adr = 8'h80 + {2'h0, i[1:0], 1'b0};
      else if (i == 5'd3) adr = 8'h86;
      else if (i < 5'd8) adr = {(i < 5'd6) ? 4'h9 : 4'ha, i[0] ? 4'h4 : 4'h2};
      else if (i == 5'd23) adr = 8'hf0;
      else adr = {4'hb + j[3:0] / 4'd3, (j[3:0] % 4'd3) << 1};
   endfunction

   // Idle lines toggle so a stale word is never mistaken for a live one
   always @(posedge mclk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         idx_q <= 5'h0;
         gap_q <= 1'b0;
         ee_valid <= 1'b0;
         ee_last <= 1'b0;
         ee_addr <= 8'h0;
         ee_word <= 16'h0;
      end else begin
         ee_valid <= 1'b0;
         ee_last <= 1'b0;
         ee_addr <= ~ee_addr;
         ee_word <= ~ee_word;
         if (start) begin
            busy_q <= 1'b1;
            idx_q <= 5'h0;
            gap_q <= 1'b0;
         end else if (busy_q && !gap_q) begin
            ee_valid <= 1'b1;
            ee_addr <= adr(idx_q);
            // Extra word after the end, corrupted, must be ignored
            ee_word <= (idx_q == 5'd23) ? ~pat(adr(idx_q)) : pat(adr(idx_q));
            ee_last <= (idx_q == 5'd22);
            busy_q <= (idx_q != 5'd23);
            idx_q <= idx_q + 5'd1;
            gap_q <= slow;
         end else begin
            gap_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> port_param_word_loader_asserts.sv
// Port-level checker for the configuration word loader
`timescale 1ns/10ps
`default_nettype none

module port_param_word_loader_asserts (
   input  wire logic         mclk,        // Core clock
   input  wire logic         sys_rst,     // Synchronous reset
   input  wire logic         ee_valid,    // Word present
   input  wire logic [7:0]   ee_addr,     // Word address
   input  wire logic [15:0]  ee_word,     // Word data
   input  wire logic         ee_last,     // Image complete
   input  wire logic [10:0]  reg_addr,    // Bus address
   input  wire logic [31:0]  reg_wdata,   // Bus write data
   input  wire logic         reg_wr,      // Write strobe
   input  wire logic         reg_rd,      // Read strobe
   input  wire logic [31:0]  reg_rdata,   // Read data
   input  wire logic         ports_ready, // Ports may start
   input  wire logic [767:0] cfg_flat     // Port registers
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence word_at(logic [7:0] a);
      ee_valid && !ports_ready && ee_addr == a;
   endsequence

   chk_ready_after_last: assert property (
      ee_last |=> ports_ready) else $error("ready late");
   chk_ready_holds: assert property (
      ports_ready && !reg_wr |=> ports_ready) else $error("ready lost");
   chk_late_ignored: assert property (
      ports_ready && ee_valid && !reg_wr |=> $stable(cfg_flat))
      else $error("word taken after ready");
   chk_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");
   chk_pm_port1: assert property (
      word_at(8'h82) |=> cfg_flat[302:296] == $past(ee_word[6:0]))
      else $error("port 1 power bits");
   chk_pm_port2: assert property (
      word_at(8'h84) |=> cfg_flat[558:552] == $past(ee_word[6:0]))
      else $error("port 2 power bits");
   chk_vga_phy_port0: assert property (
      word_at(8'h80) |=> cfg_flat[31] == $past(ee_word[7]) &&
      cfg_flat[127:120] == $past(ee_word[15:8])) else $error("port 0 word");
   chk_replay_ts: assert property (
      word_at(8'hd0) |=> cfg_flat[12:0] == $past(ee_word[12:0]) &&
      cfg_flat[153:152] == $past(ee_word[14:13])) else $error("replay");
   chk_ack_port1: assert property (
      word_at(8'he2) |=> cfg_flat[286:272] == $past(ee_word[14:0]))
      else $error("ack latency");
   chk_vc1_port2: assert property (
      word_at(8'hf4) |=> cfg_flat[726:720] == $past(ee_word[6:0]) &&
      cfg_flat[743:736] == $past(ee_word[15:8])) else $error("vc1 fields");
   chk_slot_lo_port1: assert property (
      word_at(8'h92) |=> cfg_flat[431:416] == $past(ee_word))
      else $error("port 1 slot low half");
   chk_phy3_hi_port2: assert property (
      word_at(8'hc4) |=> cfg_flat[607:592] == $past(ee_word))
      else $error("port 2 phy high half");
endmodule

bind port_param_word_loader port_param_word_loader_asserts u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .ee_valid(ee_valid), .ee_addr(ee_addr),
   .ee_word(ee_word), .ee_last(ee_last), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ports_ready(ports_ready), .cfg_flat(cfg_flat));
`default_nettype wire

// >>> port_param_word_loader_tb.sv
// Self-checking bench for the configuration word loader
`timescale 1ns/10ps
`default_nettype none
`include "port_param_consts.vh"

module port_param_word_loader_tb;
   logic         mclk = 1'b0;        // Core clock, 4 ns
   logic         sys_rst = 1'b1;     // Reset
   logic         start = 1'b0;       // Image pass kick
   logic         slow = 1'b0;        // Gapped image stream
   logic         ee_valid, ee_last;  // Image handshake
   logic [7:0]   ee_addr;            // Image address
   logic [15:0]  ee_word;            // Image word
   logic [10:0]  reg_addr = 11'h0;   // Bus address
   logic [31:0]  reg_wdata = 32'h0;  // Bus write data
   logic [31:0]  reg_rdata, rv;      // Bus read data
   logic         reg_wr = 1'b0;      // Write strobe
   logic         reg_rd = 1'b0;      // Read strobe
   logic         ports_ready;        // Ports released
   logic [767:0] cfg_flat;           // Port registers
   int           bad_count = 0;      // Mismatches
   int           n_tests = 0;        // Comparisons

   always #2 mclk = ~mclk;

   ee_image_src u_src (.mclk(mclk), .sys_rst(sys_rst), .start(start),
      .slow(slow), .ee_valid(ee_valid), .ee_addr(ee_addr),
      .ee_word(ee_word), .ee_last(ee_last));

   port_param_word_loader uut (.mclk(mclk), .sys_rst(sys_rst),
      .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_word(ee_word),
      .ee_last(ee_last), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ports_ready(ports_ready), .cfg_flat(cfg_flat));

   // Image word for an address, same pattern as the memory holds
   function automatic logic [15:0] pat(input logic [7:0] a);
      pat = {a ^ 8'h5a, a * 8'h25};
   endfunction

   function automatic logic [8:0] off(input int i);
      case (i)
         0: off = `OFF_TIMERS;
         1: off = `OFF_MODES;
         2: off = `OFF_PHY3;
         3: off = `OFF_PHY5;
         4: off = `OFF_PHYRX;
         5: off = `OFF_SLOTCAP;
         6: off = `OFF_VC1RES;
         default: off = `OFF_VC1MAP;
      endcase
   endfunction

   // Expected register after a full pass; untouched bits stay zero
   function automatic logic [31:0] ex(input int p, input int i);
      logic [7:0]  b;
      logic [15:0] pm, rp, ak, vc;
      b = 8'(2 * p);
      pm = pat(8'h80 + b);
      rp = pat(8'hd0 + b);
      ak = pat(8'he0 + b);
      vc = pat(8'hf0 + b);
      case (i)
         0: ex = {pm[7], ak[14:0], 3'h0, rp[12:0]};
         1: ex = {17'h0, pm[6:0], 8'h0};
         2: ex = {pat(8'hc0 + b), pat(8'hb0 + b)};
         3: ex = {pm[15:8], 24'h0};
         4: ex = {6'h0, rp[14:13], 24'h0};
         5: ex = (p == 0) ? 32'h0 : {pat(8'ha0 + b), pat(8'h90 + b)};
         6: ex = {9'h0, vc[6:0], 16'h0};
         default: ex = {24'h0, vc[15:8]};
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [10:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // One image pass, bounded wait for release of the ports
   task automatic run(input logic s);
      int k;
      @(posedge mclk);
      start <= 1'b1;
      slow <= s;
      @(posedge mclk);
      start <= 1'b0;
      k = 0;
      while (ports_ready !== 1'b1 && k < 200) begin
         @(posedge mclk);
         #1 k++;
      end
      chk({31'h0, ports_ready}, 32'h1); // Released
      repeat (4) @(posedge mclk);
   endtask

   task automatic check_all;
      int p, i;
      logic [31:0] e;
      for (p = 0; p < 3; p++) begin
         for (i = 0; i < 8; i++) begin
            e = ex(p, i);
            rd({p[1:0], off(i)}, rv);
            chk(rv, e); // Read
            chk(cfg_flat[p*256+i*32 +: 32], e); // Out
         end
      end
   endtask

   task automatic end_sim;
      if (bad_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Fast pass, bus overwrite, unmapped place, status, restart, slow pass
   initial begin
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      run(1'b0);
      check_all();
      wr({2'h1, `OFF_SLOTCAP}, 32'hdeadbeef);
      rd({2'h1, `OFF_SLOTCAP}, rv);
      chk(rv, 32'hdeadbeef); // Bus overwrite
      wr(11'h0fc, 32'hffffffff);
      rd(11'h0fc, rv);
      chk(rv, 32'h0); // Unmapped
      rd({`PAGE_LOADER, `OFF_LDSTAT}, rv);
      chk(rv, 32'h00011601); // Counts, not loading
      wr({`PAGE_LOADER, `OFF_LDCTL}, 32'h00000005);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, ports_ready}, 32'h0); // Restart
      run(1'b1);
      check_all();
      // Control read-back, then force release with loading off
      rd({`PAGE_LOADER, `OFF_LDCTL}, rv);
      chk(rv, 32'h00000001); // Restart bit not kept
      wr({`PAGE_LOADER, `OFF_LDCTL}, 32'h00000006);
      #1 chk({31'h0, ports_ready}, 32'h0); // Restart drops ready
      @(posedge mclk);
      #1 chk({31'h0, ports_ready}, 32'h1); // Force releases
      rd({`PAGE_LOADER, `OFF_LDCTL}, rv);
      chk(rv, 32'h00000002); // Force kept, load off
      end_sim();
   end

   // Watchdog well beyond the expected run of under a thousand nanoseconds
   initial begin
      #20000;
      bad_count++;
      end_sim();
   end
endmodule
`default_nettype wire
